// File: rtl/drive_input_terminal_functions.sv
/*
 Contact-input terminal sequence logic of the drive: local/remote switching,
 output block command, raise/lower reference with limits, output ramp and
 frequency-matched flag, plus the four documented parameters.
 Assumes command and reference sources come from logic on ref_clk_i; the
 terminal contacts and the panel key are asynchronous pins.
*/
`timescale 1ns/100ps
module drive_input_terminal_functions
#(
   parameter int N_TERM = 14,
   parameter int BLINK_CYC = drive_terminal_pkg::BLINK_HALF_CYC,
   parameter int STEP_CYC = drive_terminal_pkg::UPDN_STEP_CYC,
   parameter int ACC_CYC = drive_terminal_pkg::ACCEL_STEP_CYC
)
(
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic [11:0] param_addr_i,
   input wire logic param_wr_i,
   input wire logic param_rd_i,
   input wire logic [15:0] param_wdata_i,
   output logic [15:0] param_rdata_o,
   output logic param_ack_o,
   input wire logic [N_TERM-1:0] multi_function_inputs_i,
   input wire logic [N_TERM-1:0][7:0] terminal_function_selectors_i,
   input wire logic panel_lr_key_i,
   input wire drive_terminal_pkg::cmd_t panel_cmd_i,
   input wire logic terminal_run_i,
   input wire logic [15:0] analog_speed_input_i,
   input wire drive_terminal_pkg::cmd_t comm_cmd_i,
   input wire drive_terminal_pkg::cmd_t plc_cmd_i,
   input wire logic [15:0] search_freq_i,
   output logic remote_o,
   output logic run_o,
   output logic [15:0] speed_ref_o,
   output logic [15:0] out_freq_o,
   output logic output_enable_o,
   output logic coast_o,
   output logic output_block_indicator_o,
   output logic speed_search_o,
   output logic freq_matched_o,
   output logic invalid_input_selection_error_o,
   output logic multi_step_enable_o
);
   import drive_terminal_pkg::*;

   function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                           input logic [15:0] hi);
      logic [15:0] r;
      r = v;
      if (v > hi)
         r = hi;
      if (v < lo)
         r = lo;
      if (lo > hi)
         r = hi;
      return r;
   endfunction

   logic [15:0] ref_src_r, run_src_r, upper_r, lower_r;
   logic [N_TERM-1:0] pin_s1_r, pin_s2_r;
   logic key_s1_r, key_s2_r, key_s3_r;
   logic remote_r;
   logic [15:0] updn_ref_r, updn_nxt, out_freq_r, out_freq_nxt;
   logic run_prev_r;
   logic [31:0] blink_cnt_r;
   logic blink_r;
   logic [31:0] step_cnt_r, acc_cnt_r;
   run_state_t state_r, state_nxt;
   term_dec_t dec;
   cmd_t sel_cmd, remote_cmd;
   logic [15:0] remote_run_ref, eff_lower, up_val, dn_val, target;
   logic run_cmd, updn_ok, updn_err;
   logic step_tick, acc_tick, key_press, at_target;
   logic wr_ref_src, wr_run_src, wr_upper, wr_lower;

   // Function code scan across all terminals; several terminals may share a function
   always_comb
   begin
      dec = '0;
      for (int i = 0; i < N_TERM; i++)
      begin
         if (terminal_function_selectors_i[i] == FN_LOCAL_REMOTE)
         begin
            dec.lr_asg = 1'b1;
            dec.lr_level = dec.lr_level | pin_s2_r[i];
         end
         if (terminal_function_selectors_i[i] == FN_BLOCK_NO && pin_s2_r[i])
            dec.blocked = 1'b1;
         if (terminal_function_selectors_i[i] == FN_BLOCK_NC && !pin_s2_r[i])
            dec.blocked = 1'b1;
         if (terminal_function_selectors_i[i] == FN_UP)
         begin
            dec.up_asg = 1'b1;
            dec.up_cmd = dec.up_cmd | pin_s2_r[i];
         end
         if (terminal_function_selectors_i[i] == FN_DOWN)
         begin
            dec.dn_asg = 1'b1;
            dec.dn_cmd = dec.dn_cmd | pin_s2_r[i];
         end
         if (terminal_function_selectors_i[i] == FN_ACCEL_HOLD)
            dec.hold_asg = 1'b1;
      end
   end

   // Half a pair or a clash with accel/decel hold disables raise/lower entirely
   assign updn_err = (dec.up_asg ^ dec.dn_asg)
                     | (dec.up_asg & dec.dn_asg & dec.hold_asg);
   assign updn_ok = dec.up_asg & dec.dn_asg & ~updn_err;

   assign wr_ref_src = param_wr_i && param_addr_i == SPEED_REF_SRC_ADDR && param_wdata_i <= SRC_MAX;
   assign wr_run_src = param_wr_i && param_addr_i == RUN_SRC_ADDR && param_wdata_i <= SRC_MAX;
   assign wr_upper = param_wr_i && param_addr_i == REF_UPPER_ADDR && param_wdata_i <= UPPER_MAX;
   assign wr_lower = param_wr_i && param_addr_i == REF_LOWER_ADDR && param_wdata_i <= LOWER_MAX;

   assign key_press = key_s2_r & ~key_s3_r;

   // Remote sources per the two selectors; the terminal run input only
   // counts when the run source selects the sequence terminals
   assign remote_run_ref = (src_t'(ref_src_r[1:0]) == SRC_TERMINAL) ? analog_speed_input_i
                         : (src_t'(ref_src_r[1:0]) == SRC_COMM) ? comm_cmd_i.ref_val
                         : (src_t'(ref_src_r[1:0]) == SRC_PLC) ? plc_cmd_i.ref_val
                         : panel_cmd_i.ref_val;
   assign remote_cmd.run = (src_t'(run_src_r[1:0]) == SRC_TERMINAL) ? terminal_run_i
                         : (src_t'(run_src_r[1:0]) == SRC_COMM) ? comm_cmd_i.run
                         : (src_t'(run_src_r[1:0]) == SRC_PLC) ? plc_cmd_i.run
                         : panel_cmd_i.run;
   assign remote_cmd.ref_val = remote_run_ref;
   assign sel_cmd = remote_r ? remote_cmd : panel_cmd_i;
   assign run_cmd = sel_cmd.run;

   // Analog input replaces the lower limit whenever it is higher
   assign eff_lower = (analog_speed_input_i > lower_r) ? analog_speed_input_i : lower_r;
   assign up_val = (updn_ref_r >= upper_r) ? upper_r : updn_ref_r + 16'h0001;
   assign dn_val = (updn_ref_r == 16'h0000) ? 16'h0000 : updn_ref_r - 16'h0001;

   always_comb
   begin
      updn_nxt = updn_ref_r;
      if (run_cmd && !run_prev_r)
         updn_nxt = eff_lower;
      else if (step_tick && dec.up_cmd && !dec.dn_cmd)
         updn_nxt = up_val;
      else if (step_tick && dec.dn_cmd && !dec.up_cmd)
         updn_nxt = dn_val;
      // Both or neither pressed keep the value; only a run start or the clamp may move it
      updn_nxt = clamp16(updn_nxt, eff_lower, upper_r);
   end

   assign target = updn_ok ? updn_ref_r : clamp16(sel_cmd.ref_val, 16'h0000, UPPER_MAX);
   assign at_target = (out_freq_r == target);
   assign step_tick = (step_cnt_r == 32'(STEP_CYC - 1));
   assign acc_tick = (acc_cnt_r == 32'(ACC_CYC - 1));

   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         ST_STOP:
            if (dec.blocked)
               state_nxt = ST_BLOCK;
            else if (run_cmd)
               state_nxt = ST_RUN;
         ST_RUN:
            if (dec.blocked)
               state_nxt = ST_BLOCK;
            else if (!run_cmd && out_freq_r == 16'h0000)
               state_nxt = ST_STOP;
         ST_BLOCK:
            if (!dec.blocked)
               state_nxt = ST_SEARCH;
         ST_SEARCH:
            state_nxt = run_cmd ? ST_RUN : ST_STOP;
         default:
            state_nxt = ST_STOP;
      endcase
   end

   // Linear ramp one unit per accel tick; a real drive scales by its accel times
   always_comb
   begin
      out_freq_nxt = out_freq_r;
      case (state_r)
         ST_RUN:
            if (acc_tick)
            begin
               if (!run_cmd)
                  out_freq_nxt = (out_freq_r == 16'h0000) ? 16'h0000 : out_freq_r - 16'h0001;
               else if (out_freq_r < target)
                  out_freq_nxt = out_freq_r + 16'h0001;
               else if (out_freq_r > target)
                  out_freq_nxt = out_freq_r - 16'h0001;
            end
         ST_BLOCK:
            out_freq_nxt = 16'h0000;
         ST_SEARCH:
            out_freq_nxt = search_freq_i;
         default:
            out_freq_nxt = 16'h0000;
      endcase
   end

   // Contacts and key are asynchronous pins: two stages before any logic
   always_ff @(posedge ref_clk_i)
   begin
      pin_s1_r <= multi_function_inputs_i;
      pin_s2_r <= pin_s1_r;
      key_s1_r <= panel_lr_key_i;
      key_s2_r <= key_s1_r;
      key_s3_r <= key_s2_r;
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         ref_src_r <= SRC_RESET;
         run_src_r <= SRC_RESET;
         upper_r <= UPPER_RESET;
         lower_r <= LOWER_RESET;
      end
      else
      begin
         if (wr_ref_src)
            ref_src_r <= param_wdata_i;
         if (wr_run_src)
            run_src_r <= param_wdata_i;
         if (wr_upper)
            upper_r <= param_wdata_i;
         if (wr_lower)
            lower_r <= param_wdata_i;
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         param_rdata_o <= 16'h0000;
         param_ack_o <= 1'b0;
      end
      else
      begin
         param_ack_o <= param_rd_i | param_wr_i;
         case (param_addr_i)
            SPEED_REF_SRC_ADDR: param_rdata_o <= ref_src_r;
            RUN_SRC_ADDR: param_rdata_o <= run_src_r;
            REF_UPPER_ADDR: param_rdata_o <= upper_r;
            REF_LOWER_ADDR: param_rdata_o <= lower_r;
            default: param_rdata_o <= 16'h0000;
         endcase
      end
   end

   // Panel key only toggles when no terminal owns the local/remote choice
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
         remote_r <= 1'b1;
      else if (dec.lr_asg)
         remote_r <= dec.lr_level;
      else if (key_press)
         remote_r <= ~remote_r;
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         state_r <= ST_STOP;
         out_freq_r <= 16'h0000;
         updn_ref_r <= LOWER_RESET;
         run_prev_r <= 1'b0;
         step_cnt_r <= 32'h0000_0000;
         acc_cnt_r <= 32'h0000_0000;
      end
      else
      begin
         state_r <= state_nxt;
         out_freq_r <= out_freq_nxt;
         updn_ref_r <= updn_nxt;
         run_prev_r <= run_cmd;
         step_cnt_r <= step_tick ? 32'h0000_0000 : step_cnt_r + 32'h0000_0001;
         acc_cnt_r <= acc_tick ? 32'h0000_0000 : acc_cnt_r + 32'h0000_0001;
      end
   end

   // Blink restarts on each block so the indicator always opens lit
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i || state_r != ST_BLOCK)
      begin
         blink_cnt_r <= 32'h0000_0000;
         blink_r <= 1'b1;
      end
      else if (blink_cnt_r == 32'(BLINK_CYC - 1))
      begin
         blink_cnt_r <= 32'h0000_0000;
         blink_r <= ~blink_r;
      end
      else
         blink_cnt_r <= blink_cnt_r + 32'h0000_0001;
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         remote_o <= 1'b1;
         run_o <= 1'b0;
         speed_ref_o <= 16'h0000;
         out_freq_o <= 16'h0000;
         output_enable_o <= 1'b0;
         coast_o <= 1'b0;
         output_block_indicator_o <= 1'b0;
         speed_search_o <= 1'b0;
         freq_matched_o <= 1'b0;
         invalid_input_selection_error_o <= 1'b0;
         multi_step_enable_o <= 1'b1;
      end
      else
      begin
         remote_o <= remote_r;
         run_o <= (state_r == ST_RUN);
         speed_ref_o <= target;
         out_freq_o <= out_freq_r;
         output_enable_o <= (state_r == ST_RUN) && !dec.blocked;
         coast_o <= (state_r == ST_BLOCK);
         output_block_indicator_o <= (state_r == ST_BLOCK) && blink_r;
         speed_search_o <= (state_r == ST_SEARCH);
         freq_matched_o <= (state_r == ST_RUN) && run_cmd && at_target;
         invalid_input_selection_error_o <= updn_err;
         multi_step_enable_o <= ~(dec.up_asg | dec.dn_asg);
      end
   end

endmodule

// File: rtl/drive_terminal_pkg.sv
/*
 Shared constants and types for the contact-input terminal sequence block:
 parameter addresses, reset values, terminal function codes, timing counts.
 Assumes one 40 MHz clock; speeds and limits are in units of 0.1 percent of
 the maximum output frequency.
*/
package drive_terminal_pkg;

   localparam logic [11:0] SPEED_REF_SRC_ADDR = 12'h1a0;
   localparam logic [11:0] RUN_SRC_ADDR = 12'h1a1;
   localparam logic [11:0] REF_UPPER_ADDR = 12'h2e0;
   localparam logic [11:0] REF_LOWER_ADDR = 12'h2e1;

   localparam logic [15:0] SRC_RESET = 16'h0003;
   localparam logic [15:0] SRC_MAX = 16'h0003;
   localparam logic [15:0] UPPER_RESET = 16'h03e8;
   localparam logic [15:0] UPPER_MAX = 16'h044c;
   localparam logic [15:0] LOWER_RESET = 16'h0000;
   localparam logic [15:0] LOWER_MAX = 16'h0442;

   localparam logic [7:0] FN_LOCAL_REMOTE = 8'h01;
   localparam logic [7:0] FN_BLOCK_NO = 8'h08;
   localparam logic [7:0] FN_BLOCK_NC = 8'h09;
   localparam logic [7:0] FN_UP = 8'h0a;
   localparam logic [7:0] FN_DOWN = 8'h0b;
   localparam logic [7:0] FN_ACCEL_HOLD = 8'h0e;

   localparam int CLK_HZ = 40000000;
   localparam int BLINK_HALF_MS = 500;
   localparam int BLINK_HALF_CYC = BLINK_HALF_MS * (CLK_HZ / 1000);
   localparam int UPDN_STEP_MS = 10;
   localparam int UPDN_STEP_CYC = UPDN_STEP_MS * (CLK_HZ / 1000);
   localparam int ACCEL_STEP_US = 100;
   localparam int ACCEL_STEP_CYC = ACCEL_STEP_US * (CLK_HZ / 1000000);

   typedef enum logic [1:0] {
      SRC_PANEL = 2'b00,
      SRC_TERMINAL = 2'b01,
      SRC_COMM = 2'b10,
      SRC_PLC = 2'b11
   } src_t;

   typedef enum logic [1:0] {
      ST_STOP = 2'b00,
      ST_RUN = 2'b01,
      ST_BLOCK = 2'b10,
      ST_SEARCH = 2'b11
   } run_state_t;

   typedef struct packed {
      logic lr_asg;
      logic lr_level;
      logic blocked;
      logic up_asg;
      logic dn_asg;
      logic hold_asg;
      logic up_cmd;
      logic dn_cmd;
   } term_dec_t;

   typedef struct packed {
      logic run;
      logic [15:0] ref_val;
   } cmd_t;

endpackage

// File: verification/drive_terminal_asserts.sv
/* Port checks for the terminal sequence block.
 Assumes one clock and the synchronous active-high reset. */
`timescale 1ns/100ps
module drive_terminal_asserts
import drive_terminal_pkg::*;
#(
   parameter int N_TERM = 14
)
(
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic [N_TERM-1:0][7:0] terminal_function_selectors_i,
   input wire logic run_o,
   input wire logic [15:0] speed_ref_o,
   input wire logic [15:0] out_freq_o,
   input wire logic output_enable_o,
   input wire logic coast_o,
   input wire logic output_block_indicator_o,
   input wire logic speed_search_o,
   input wire logic freq_matched_o,
   input wire logic invalid_input_selection_error_o,
   input wire logic multi_step_enable_o
);
   logic up_asg;
   logic dn_asg;
   logic hold_asg;
   always_comb
   begin
      up_asg = 1'b0;
      dn_asg = 1'b0;
      hold_asg = 1'b0;
      for (int i = 0; i < N_TERM; i++)
      begin
         up_asg = up_asg | (terminal_function_selectors_i[i] == FN_UP);
         dn_asg = dn_asg | (terminal_function_selectors_i[i] == FN_DOWN);
         hold_asg = hold_asg | (terminal_function_selectors_i[i] == FN_ACCEL_HOLD);
      end
   end
   default clocking @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);
   property p_block_oe;
      coast_o |-> !output_enable_o;
   endproperty
   a_block_oe: assert property (p_block_oe) else $error("stage on while blocked");
   property p_ind_lit;
      $rose(coast_o) |-> output_block_indicator_o;
   endproperty
   a_ind_lit: assert property (p_ind_lit) else $error("indicator dark at block");
   property p_ind_idle;
      !coast_o |-> !output_block_indicator_o;
   endproperty
   a_ind_idle: assert property (p_ind_idle) else $error("indicator lit unblocked");
   property p_release;
      $fell(coast_o) |-> ##[0:1] speed_search_o;
   endproperty
   a_release: assert property (p_release) else $error("no search on release");
   property p_search_pulse;
      speed_search_o |=> !speed_search_o;
   endproperty
   a_search_pulse: assert property (p_search_pulse) else $error("search pulse too long");
   property p_match;
      freq_matched_o |-> run_o && (out_freq_o == speed_ref_o || $past(out_freq_o) == $past(speed_ref_o));
   endproperty
   a_match: assert property (p_match) else $error("matched while ramping");
   property p_multi_off;
      (up_asg || dn_asg) [*3] |-> !multi_step_enable_o;
   endproperty
   a_multi_off: assert property (p_multi_off) else $error("multi-step left on");
   property p_multi_on;
      (!up_asg && !dn_asg) [*3] |-> multi_step_enable_o;
   endproperty
   a_multi_on: assert property (p_multi_on) else $error("multi-step left off");
   property p_err_single;
      (up_asg != dn_asg) [*3] |-> invalid_input_selection_error_o;
   endproperty
   a_err_single: assert property (p_err_single) else $error("unpaired raise/lower");
   property p_err_hold;
      (up_asg && dn_asg && hold_asg) [*3] |-> invalid_input_selection_error_o;
   endproperty
   a_err_hold: assert property (p_err_hold) else $error("raise/lower with hold");
   property p_err_none;
      (up_asg == dn_asg && !(up_asg && hold_asg)) [*3] |-> !invalid_input_selection_error_o;
   endproperty
   a_err_none: assert property (p_err_none) else $error("error without cause");
endmodule

bind drive_input_terminal_functions drive_terminal_asserts #(.N_TERM(N_TERM)) drive_terminal_asserts_inst (
   .ref_clk_i, .rst_i, .terminal_function_selectors_i, .run_o, .speed_ref_o, .out_freq_o,
   .output_enable_o, .coast_o, .output_block_indicator_o, .speed_search_o, .freq_matched_o,
   .invalid_input_selection_error_o, .multi_step_enable_o);

// File: verification/contact_bank.sv
/* Contact model for the terminal pins: PLC output card or switches.
 Assumes the bench sets wanted levels; slow contacts lag a few cycles. */
`timescale 1ns/100ps
module contact_bank
#(
   parameter int N_TERM = 14
)
(
   input wire logic ref_clk_i,
   input wire logic [N_TERM-1:0] want_i,
   input wire logic slow_i,
   output logic [N_TERM-1:0] pins_o
);
   logic [N_TERM-1:0] pins_r = '0;
   logic [2:0] age_r = '0;
   assign pins_o = pins_r;
   // A relay picks up late: a slow contact follows only a request held 5 cycles
   always @(posedge ref_clk_i)
   begin
      age_r <= (want_i != pins_r) ? age_r + 3'h1 : 3'h0;
      if (!slow_i || age_r >= 3'h4)
         pins_r <= want_i;
   end
endmodule

// File: verification/testbench.sv
/* Self-checking bench for the terminal sequence block.
 Assumes short blink, step and ramp counts; parameter reads are queued. */
`timescale 1ns/100ps
module testbench;
   import drive_terminal_pkg::*;
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [11:0] addr = '0;
   logic wr = 1'b0, rd = 1'b0, key = 1'b0, slow = 1'b0, trun = 1'b0;
   logic [15:0] wdata = '0, ana = '0, sfreq = '0;
   logic [13:0] want = '0;
   logic [13:0][7:0] sel = '0;
   cmd_t panel = '0, comm = '0, plc = '0;
   logic [15:0] rdata, sref, ofreq;
   logic [13:0] pins;
   logic ack, remote, run, oe, coast, ind, search, match, err, mstep;
   logic [16:0] expq[$];
   logic [16:0] qe;
   logic [15:0] rlow;
   logic [15:0] rexp[4];
   logic rrun[4];
   int err_total = 0;
   int cmp_count = 0;
   int n;
   always #12.5 ref_clk_i = ~ref_clk_i;
   drive_input_terminal_functions #(.N_TERM(14), .BLINK_CYC(4), .STEP_CYC(3), .ACC_CYC(2))
      drive_input_terminal_functions_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .param_addr_i(addr),
      .param_wr_i(wr), .param_rd_i(rd), .param_wdata_i(wdata), .param_rdata_o(rdata), .param_ack_o(ack),
      .multi_function_inputs_i(pins), .terminal_function_selectors_i(sel), .panel_lr_key_i(key),
      .panel_cmd_i(panel), .terminal_run_i(trun), .analog_speed_input_i(ana), .comm_cmd_i(comm),
      .plc_cmd_i(plc), .search_freq_i(sfreq), .remote_o(remote), .run_o(run), .speed_ref_o(sref),
      .out_freq_o(ofreq), .output_enable_o(oe), .coast_o(coast), .output_block_indicator_o(ind),
      .speed_search_o(search), .freq_matched_o(match), .invalid_input_selection_error_o(err),
      .multi_step_enable_o(mstep));
   contact_bank #(.N_TERM(14)) contact_bank_inst (.ref_clk_i(ref_clk_i), .want_i(want), .slow_i(slow),
      .pins_o(pins));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      cmp_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(negedge ref_clk_i);
   endtask
   // One strobe cycle; address held until the edge that samples the ack
   task automatic acc(input logic [11:0] a, input logic w, input logic [15:0] d, input logic [15:0] e);
      addr = a;
      wr = w;
      rd = !w;
      wdata = d;
      expq.push_back({!w, e});
      cyc(1);
      wr = 1'b0;
      rd = 1'b0;
      cyc(1);
   endtask
   task automatic press();
      key = 1'b1;
      cyc(6);
      key = 1'b0;
      cyc(6);
   endtask
   task automatic end_sim();
      if (err_total == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(negedge ref_clk_i)
      if (ack === 1'b1)
      begin
         if (expq.size() == 0)
            chk(16'h0001, 16'h0000, "ack without request");
         else
         begin
            qe = expq.pop_front();
            if (qe[16])
               chk(rdata, qe[15:0], "param read");
         end
      end
   initial
   begin
      #(25 * 20000);
      err_total++;
      end_sim();
   end
   initial
   begin
      void'($urandom(57736));
      cyc(10);
      rst_i = 1'b0;
      cyc(1);
      acc(SPEED_REF_SRC_ADDR, 1'b0, 16'h0, SRC_RESET);
      acc(RUN_SRC_ADDR, 1'b0, 16'h0, SRC_RESET);
      acc(REF_UPPER_ADDR, 1'b0, 16'h0, UPPER_RESET);
      acc(REF_LOWER_ADDR, 1'b0, 16'h0, LOWER_RESET);
      acc(12'h1a2, 1'b0, 16'h0, 16'h0000);
      for (int v = 0; v < 5; v++)
      begin
         acc(SPEED_REF_SRC_ADDR, 1'b1, v[15:0], 16'h0);
         acc(SPEED_REF_SRC_ADDR, 1'b0, 16'h0, v > 3 ? 16'h0003 : v[15:0]);
         acc(RUN_SRC_ADDR, 1'b1, v[15:0], 16'h0);
         acc(RUN_SRC_ADDR, 1'b0, 16'h0, v > 3 ? 16'h0003 : v[15:0]);
      end
      acc(REF_UPPER_ADDR, 1'b1, UPPER_MAX, 16'h0);
      acc(REF_UPPER_ADDR, 1'b1, UPPER_MAX + 16'h0001, 16'h0);
      acc(REF_UPPER_ADDR, 1'b0, 16'h0, UPPER_MAX);
      acc(REF_LOWER_ADDR, 1'b1, LOWER_MAX, 16'h0);
      acc(REF_LOWER_ADDR, 1'b1, LOWER_MAX + 16'h0001, 16'h0);
      acc(REF_LOWER_ADDR, 1'b0, 16'h0, LOWER_MAX);
      rlow = 16'($urandom_range(1090));
      acc(REF_LOWER_ADDR, 1'b1, rlow, 16'h0);
      acc(REF_LOWER_ADDR, 1'b0, 16'h0, rlow);
      acc(REF_LOWER_ADDR, 1'b1, 16'h0000, 16'h0);
      panel = {1'b1, 16'($urandom_range(1000))};
      comm = {1'b0, 16'($urandom_range(1000))};
      plc = {1'b0, 16'($urandom_range(1000))};
      ana = 16'($urandom_range(1000));
      rexp = '{panel.ref_val, ana, comm.ref_val, plc.ref_val};
      rrun = '{1'b1, 1'b0, 1'b0, 1'b0};
      // Downward order: the run command only ever rises, so no stop ramp is needed
      for (int v = 3; v >= 0; v--)
      begin
         acc(SPEED_REF_SRC_ADDR, 1'b1, v[15:0], 16'h0);
         acc(RUN_SRC_ADDR, 1'b1, v[15:0], 16'h0);
         cyc(4);
         chk(sref, rexp[v], "reference source");
         chk({15'h0, run}, {15'h0, rrun[v]}, "run source");
      end
      plc.run = 1'b1;
      acc(SPEED_REF_SRC_ADDR, 1'b1, 16'h0003, 16'h0);
      acc(RUN_SRC_ADDR, 1'b1, 16'h0003, 16'h0);
      press();
      chk(sref, panel.ref_val, "panel key to local");
      sel[2] = FN_LOCAL_REMOTE;
      want[2] = 1'b1;
      slow = 1'b1;
      cyc(14);
      chk(sref, plc.ref_val, "terminal to remote");
      // Watch every cycle: a one-cycle toggle by the key would hide behind the terminal
      key = 1'b1;
      for (int k = 0; k < 12; k++)
      begin
         cyc(1);
         key = (k < 5);
         chk(remote, 1'b1, "panel key ignored");
      end
      want[2] = 1'b0;
      cyc(14);
      chk(remote, 1'b0, "terminal to local");
      want[2] = 1'b1;
      slow = 1'b0;
      sel[3] = FN_UP;
      cyc(6);
      chk(err, 1'b1, "raise alone");
      sel[4] = FN_DOWN;
      cyc(6);
      chk(err, 1'b0, "raise and lower");
      chk(mstep, 1'b0, "multi-step off");
      sel[5] = FN_ACCEL_HOLD;
      cyc(6);
      chk(err, 1'b1, "with accel hold");
      sel[5] = 8'h00;
      acc(REF_UPPER_ADDR, 1'b1, 16'h0014, 16'h0);
      acc(REF_LOWER_ADDR, 1'b1, 16'h0005, 16'h0);
      acc(RUN_SRC_ADDR, 1'b1, 16'h0001, 16'h0);
      ana = 16'h0008;
      cyc(4);
      trun = 1'b1;
      cyc(6);
      chk(sref, 16'h0008, "start at analog floor");
      want[3] = 1'b1;
      cyc(60);
      chk(sref, 16'h0014, "upper clamp");
      want[4] = 1'b1;
      cyc(12);
      chk(sref, 16'h0014, "both held");
      want[3] = 1'b0;
      cyc(60);
      chk(sref, 16'h0008, "analog floor clamp");
      want[4] = 1'b0;
      cyc(40);
      chk(ofreq, 16'h0008, "ramped to floor");
      chk(match, 1'b1, "frequency matched");
      ana = 16'h0002;
      want[4] = 1'b1;
      cyc(30);
      want[4] = 1'b0;
      chk(sref, 16'h0005, "lower limit clamp");
      sfreq = 16'h0003;
      sel[0] = FN_BLOCK_NO;
      want[0] = 1'b1;
      cyc(10);
      chk(coast, 1'b1, "coast while blocked");
      chk(oe, 1'b0, "stage off while blocked");
      n = 0;
      repeat (20)
      begin
         cyc(1);
         n += (ind === 1'b1);
      end
      chk({15'h0, n > 0 && n < 20}, 16'h0001, "indicator blinks");
      want[0] = 1'b0;
      n = 0;
      while (search !== 1'b1 && n < 12)
      begin
         cyc(1);
         n++;
      end
      chk(search, 1'b1, "search on release");
      // Frequency output trails the search pulse by one register stage
      cyc(1);
      chk(ofreq, sfreq, "search speed loaded");
      sel[0] = FN_BLOCK_NC;
      cyc(8);
      chk(coast, 1'b1, "open contact blocks");
      want[0] = 1'b1;
      cyc(12);
      chk(coast, 1'b0, "closed contact runs");
      chk(oe, 1'b1, "stage on after release");
      cyc(4);
      chk(16'(expq.size()), 16'h0, "acks missing");
      end_sim();
   end
endmodule
